// file: bench/grf_checker.sv
// Checker: port-level assertions for the gyro rate conditioning block
`timescale 1ns/100ps
module grf_checker (
  input wire logic                 ref_clk_in,        // Clock
  input wire logic                 rst_n_in,          // Reset, low
  input wire logic [7:0]           reg_addr_in,       // Address
  input wire logic                 reg_rd_in,         // Read strobe
  input wire logic [7:0]           reg_rdata_out,     // Read data
  input wire grf_pkg::grf_sample_t raw_sample_in,     // Readings
  input wire grf_pkg::grf_sample_t sample_out,        // Outputs
  input wire logic                 sample_strobe_out, // Update pulse
  input wire logic [3:0]           filter_mode_out,   // Mode code
  input wire logic                 fifo_valid_out,    // Not empty
  input wire logic                 fifo_ready_in      // Pop
);
  logic [3:0] since_reg;  // Cycles since last strobe, saturating
  logic [3:0] since_next; // Next count
  // Count up from each strobe; saturate so long gaps never wrap
  always_comb
  begin
    since_next = (since_reg == 4'hf) ? since_reg : since_reg + 4'h1;
    if (sample_strobe_out)
      since_next = 4'h0;
  end
  // Register only
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      since_reg <= 4'hf;
    else
      since_reg <= since_next;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Read request at a given address
  sequence rd_s(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  strobe_pulse_a: assert property (sample_strobe_out |=> !sample_strobe_out)
    else $error("strobe longer than one cycle");
  sample_hold_a: assert property (!sample_strobe_out |-> $stable(sample_out))
    else $error("outputs changed without strobe");
  x_raw_a: assert property (sample_strobe_out |->
    sample_out.x[15:1] == $past(raw_sample_in.x[15:1]))
    else $error("x output not the raw reading");
  mode_code_a: assert property (filter_mode_out <= 4'h9)
    else $error("filter mode code out of range");
  valid_rise_a: assert property ($rose(fifo_valid_out) |-> since_reg <= 4'h6)
    else $error("fifo filled away from a strobe");
  valid_fall_a: assert property ($fell(fifo_valid_out) |-> $past(fifo_ready_in))
    else $error("fifo emptied without a pop");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  bypass_bits_a: assert property (rd_s(grf_pkg::GYRO_CONFIG_ADDR) |=>
    reg_rdata_out[7:2] == 6'h00)
    else $error("gyro config upper bits not zero");
endmodule
bind grf_top grf_checker u_chk (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .raw_sample_in, .sample_out, .sample_strobe_out, .filter_mode_out,
  .fifo_valid_out, .fifo_ready_in);

// file: bench/grf_host_model.sv
// Host model: drives register reads and writes as the processor would
`timescale 1ns/100ps
module grf_host_model (
  input  wire logic       clk_in,    // Clock
  output logic      [7:0] addr_out,  // Register address
  output logic            wr_out,    // Write strobe
  output logic      [7:0] wdata_out, // Write data
  output logic            rd_out,    // Read strobe
  input  wire logic [7:0] rdata_in   // Read data
);
  int gap = 0; // Idle cycles before a request, for slow hosts
  // Idle bus at time zero
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One write, held through the taking edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;  // Released lines must not look still valid
    wdata_out = ~d;
  endtask
  // One read; data is registered at the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    repeat (gap + 1) @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask
endmodule

// file: bench/grf_top_tb.sv
// Testbench: registers, filter modes, rates, offsets, sync capture, FIFO policy
`timescale 1ns/100ps
module grf_top_tb;
  localparam int T1K = 20; // Short tick counts keep the run brief
  localparam int T8K = 5;
  localparam int T32K = 2;
  logic                 ref_clk_in = 1'b0; // Clock
  logic                 rst_n_in = 1'b0;   // Reset
  logic [7:0]           addr, wdata, rdata, v, rv;
  logic                 wr, rd, pin = 1'b0, fready = 1'b0, stb, fvalid, r;
  grf_pkg::grf_sample_t raw = '0, smp, e;  // Readings, outputs, expected
  logic [3:0]           mode;
  logic [7:0]           fdata, offs[4];
  logic [7:0]           q[$];              // Expected FIFO bytes
  int                   num_errors = 0, total_checks = 0, n;
  logic [7:0] ra[9] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h23, 8'h00};
  logic [7:0] rm[9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h03, 8'h70, 8'h00};
  logic [1:0] cb[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic [2:0] cs[7] = '{3'h0, 3'h7, 3'h1, 3'h6, 3'h3, 3'h5, 3'h2};
  always #2.5 ref_clk_in = ~ref_clk_in;
  grf_top #(.TICK_1K(T1K), .TICK_8K(T8K), .TICK_32K(T32K)) dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .raw_sample_in(raw),
    .frame_sync_pin_in(pin), .sample_out(smp), .sample_strobe_out(stb),
    .filter_mode_out(mode), .fifo_data_out(fdata), .fifo_valid_out(fvalid),
    .fifo_ready_in(fready));
  grf_host_model h (.clk_in(ref_clk_in), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .rd_out(rd), .rdata_in(rdata));
  // Value comparison
  task automatic chk_v(input string s, input logic [63:0] x, input logic [63:0] g);
    total_checks++;
    if (x !== g)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // Count comparison
  task automatic chk_n(input string s, input int x, input int g);
    total_checks++;
    if (x != g)
    begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", s, x, g);
    end
  endtask
  // Step cycles; inputs move 1 ns after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  // Wait for the next strobe, bounded; returns cycles waited
  task automatic wait_stb(output int k);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (!stb && k < 6000);
    // A stale divider count can delay the first strobe by 255 ticks
    if (!stb)
    begin
      num_errors++;
      $display("Error strobe expected pulse seen timeout");
      complete_run();
    end
  endtask
  task automatic cfg(input logic [1:0] b, input logic [2:0] s, input logic [2:0] sel,
                     input logic pol, input logic [7:0] d);
    h.write(grf_pkg::GYRO_CONFIG_ADDR, {6'h00, b});
    h.write(grf_pkg::FILTER_SYNC_FIFO_ADDR, {1'b0, pol, sel, s});
    h.write(grf_pkg::RATE_DIVIDER_ADDR, d);
  endtask
  // Expected outputs: offsets on y and z only, sync bit into the chosen byte
  function automatic grf_pkg::grf_sample_t exp_s(grf_pkg::grf_sample_t x, logic [2:0] sel,
                                                 logic lat);
    exp_s = x;
    exp_s.y = x.y + {offs[0], offs[1]};
    exp_s.z = x.z + {offs[2], offs[3]};
    case (sel)
      grf_pkg::SYNC_TEMP: exp_s.temp[0] = lat;
      grf_pkg::SYNC_X: exp_s.x[0] = lat;
      grf_pkg::SYNC_Y: exp_s.y[0] = lat;
      grf_pkg::SYNC_Z: exp_s.z[0] = lat;
      default: ; // Off or reserved: nothing captured
    endcase
  endfunction
  function automatic logic [3:0] exp_mode(logic [1:0] b, logic [2:0] s);
    return b[0] ? grf_pkg::MODE_WIDE_8173 : (b[1] ? grf_pkg::MODE_WIDE_3281 : {1'b0, s});
  endfunction
  // Strobe period; divider counts only in the 1 kHz modes
  function automatic int exp_per(logic [1:0] b, logic [2:0] s, logic [7:0] d);
    if (b != 2'h0)
      return T32K;
    return (s == 3'h0 || s == 3'h7) ? T8K : T1K * (1 + d);
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well beyond the expected run
  initial
  begin
    cyc(40000);
    num_errors++;
    $display("Error watchdog expected done seen timeout");
    complete_run();
  end
  initial
  begin
    void'($urandom(5688));
    cyc(6);
    rst_n_in = 1'b1;
    h.gap = 2; // Slow host for the register pass
    for (int i = 0; i < 9; i++)
    begin
      v = 8'($urandom);
      h.read(ra[i], rv);
      chk_v("reset value", 64'h0, {56'h0, rv});
      h.write(ra[i], v);
      h.read(ra[i], rv);
      chk_v("register", {56'h0, v & rm[i]}, {56'h0, rv});
      if (i < 4)
        offs[i] = v;
    end
    h.gap = 0;
    h.write(grf_pkg::FIFO_ENABLE_ADDR, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 32; i++)
    begin
      cfg(2'(i / 8), 3'(i), 3'h0, 1'b0, 8'h00);
      cyc(3);
      chk_v("filter mode", {60'h0, exp_mode(2'(i / 8), 3'(i))}, {60'h0, mode});
    end
    $display("test modes done");
    for (int i = 0; i < 7; i++)
    begin
      raw = {$urandom, $urandom};
      v = 8'($urandom % 4);
      cfg(cb[i], cs[i], 3'h0, 1'b0, v);
      wait_stb(n);
      wait_stb(n);
      chk_v("sample", exp_s(raw, 3'h0, 1'b0), smp);
      wait_stb(n);
      chk_n("strobe period", exp_per(cb[i], cs[i], v), n);
    end
    $display("test rates done");
    for (int sel = 0; sel < 8; sel++)
    begin
      cfg(2'h0, 3'h0, 3'(sel), 1'b0, 8'h00);
      wait_stb(n);
      pin = 1'b1; // One-cycle strobe must still be caught
      cyc(1);
      pin = 1'b0;
      wait_stb(n);
      chk_v("sync set", exp_s(raw, 3'(sel), 1'b1), smp);
      wait_stb(n);
      chk_v("sync clear", exp_s(raw, 3'(sel), 1'b0), smp);
    end
    $display("test sync done");
    for (int pol = 0; pol < 2; pol++)
    begin
      fready = 1'b1;
      cfg(2'h0, 3'h1, 3'h0, 1'(pol), 8'h00);
      cyc(10); // Empty whatever earlier tests left behind
      fready = 1'b0;
      q.delete();
      wait_stb(n);
      h.write(grf_pkg::FIFO_ENABLE_ADDR, 8'h70);
      repeat (3)
      begin
        wait_stb(n);
        e = exp_s(raw, 3'h0, 1'b0);
        q.push_back(e.x[15:8]);
        q.push_back(e.x[7:0]);
        q.push_back(e.y[15:8]);
        q.push_back(e.y[7:0]);
        q.push_back(e.z[15:8]);
        q.push_back(e.z[7:0]);
        raw = {$urandom, $urandom};
      end
      h.write(grf_pkg::FIFO_ENABLE_ADDR, 8'h00);
      cyc(10);
      q = (pol == 1) ? q[0:7] : q[10:17]; // Drop new or lose oldest
      for (int k = 0; k < 200 && q.size() > 0; k++)
      begin
        fready = 1'($urandom);
        r = fready;
        v = fdata;
        e[0] = fvalid;
        cyc(1);
        if (r && e[0])
          chk_v("fifo byte", {56'h0, q.pop_front()}, {56'h0, v});
      end
      fready = 1'b0;
      chk_n("fifo left", 0, q.size());
      chk_v("fifo empty", 64'h0, {63'h0, fvalid});
    end
    $display("test fifo done");
    complete_run();
  end
endmodule

// file: verilog/grf_pkg.sv
// Package: register map, reset values, timing constants and sample carrier
package grf_pkg;
  // Register offsets
  localparam logic [7:0] Y_AXIS_OFFSET_HIGH_ADDR = 8'h15;
  localparam logic [7:0] Y_AXIS_OFFSET_LOW_ADDR  = 8'h16;
  localparam logic [7:0] Z_AXIS_OFFSET_HIGH_ADDR = 8'h17;
  localparam logic [7:0] Z_AXIS_OFFSET_LOW_ADDR  = 8'h18;
  localparam logic [7:0] RATE_DIVIDER_ADDR       = 8'h19;
  localparam logic [7:0] FILTER_SYNC_FIFO_ADDR   = 8'h1A;
  localparam logic [7:0] GYRO_CONFIG_ADDR        = 8'h1B;
  localparam logic [7:0] FIFO_ENABLE_ADDR        = 8'h23;
  // Reset value of every register in this block
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions in the filter/sync/fifo configuration register
  localparam int FULL_POLICY_BIT = 6;
  localparam int SYNC_SEL_LSB    = 3;
  localparam int FILTER_SET_LSB  = 0;
  // Field positions in gyro configuration and fifo enable
  localparam int BYPASS_LSB   = 0;
  localparam int X_FIFO_BIT   = 6;
  localparam int Y_FIFO_BIT   = 5;
  localparam int Z_FIFO_BIT   = 4;
  // Sync bit destinations
  localparam logic [2:0] SYNC_OFF  = 3'h0;
  localparam logic [2:0] SYNC_TEMP = 3'h1;
  localparam logic [2:0] SYNC_X    = 3'h2;
  localparam logic [2:0] SYNC_Y    = 3'h3;
  localparam logic [2:0] SYNC_Z    = 3'h4;
  // Filter mode codes reported outward (0..7 follow the filter setting)
  localparam logic [3:0] MODE_WIDE_8173 = 4'h8;
  localparam logic [3:0] MODE_WIDE_3281 = 4'h9;
  localparam logic [2:0] SET_LOWEST     = 3'h0;
  localparam logic [2:0] SET_HIGHEST    = 3'h7;
  // Clock and internal rates
  localparam longint CLK_HZ      = 200_000_000;
  localparam longint RATE_1K_HZ  = 1_000;
  localparam longint RATE_8K_HZ  = 8_000;
  localparam longint RATE_32K_HZ = 32_000;
  localparam int TICK_1K_CYCLES  = int'(CLK_HZ / RATE_1K_HZ);
  localparam int TICK_8K_CYCLES  = int'(CLK_HZ / RATE_8K_HZ);
  localparam int TICK_32K_CYCLES = int'(CLK_HZ / RATE_32K_HZ);
  localparam int TICK_WIDTH      = 18;
  // FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // One sample set, all axes plus temperature
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] temp;
  } grf_sample_t;
endpackage

// file: verilog/grf_top.sv
// Gyro rate conditioning: offsets, filter mode, rate divider, sync capture, FIFO feed
// What this block does
// - Hold 16-bit two's complement offset for the Y and Z axes
// - Add Y/Z axis offset before storing Y/Z output; X passes unchanged
// - Output rate is internal rate over divider+1
// - Divider input is the 1 kHz internal rate
// - Divider only with bypass 00, setting 1..6
// - Divided strobe updates outputs and feeds FIFO
// - Full policy one: drop writes when full
// - Full policy zero: overwrite oldest when full
// - Sync select picks temp/X/Y/Z low bit 0
// - Latch frame sync until next sample strobe
// - Filter setting used only when bypass 00
// - Bypass bits and setting choose bandwidth, rate
// - Bypass bits sit in gyro config low bits
// - Enabled axes push high then low byte
`timescale 1ns/100ps

// Byte FIFO with optional overwrite of the oldest entry
module grf_fifo #(
  parameter int WIDTH = grf_pkg::FIFO_WIDTH,
  parameter int DEPTH = grf_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_in,      // Clock
  input  wire logic             rst_n_in,    // Async reset, low
  input  wire logic             overwrite_in, // Full push drops oldest
  input  wire logic             in_valid_in, // Push request
  output logic                  in_ready_out, // Push accepted
  input  wire logic [WIDTH-1:0] in_data_in,  // Push data
  output logic                  out_valid_out, // Data available
  input  wire logic             out_ready_in, // Pop request
  output logic      [WIDTH-1:0] out_data_out  // Oldest entry
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("grf_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];        // Storage
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push, pop, full;

  // Full pushes are taken only when overwriting is allowed
  always_comb
  begin
    full         = (count_reg == (AW+1)'(DEPTH));
    in_ready_out = !full || overwrite_in;
    push         = in_valid_in && in_ready_out;
    pop          = out_ready_in && (count_reg != '0);
    wr_ptr_next  = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next  = rd_ptr_reg;
    count_next   = count_reg;
    if (push && full)
    begin
      // Oldest entry is lost, count stays at full
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    else
    begin
      if (pop)
        rd_ptr_next = rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_next = count_reg + 1'b1;
      else if (pop && !push)
        count_next = count_reg - 1'b1;
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_in;
  end

  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
endmodule

// Top: register file, rate generation, sample update and FIFO feed
module grf_top #(
  parameter int TICK_1K  = grf_pkg::TICK_1K_CYCLES,  // Cycles per 1 kHz tick
  parameter int TICK_8K  = grf_pkg::TICK_8K_CYCLES,  // Cycles per 8 kHz tick
  parameter int TICK_32K = grf_pkg::TICK_32K_CYCLES  // Cycles per 32 kHz tick
) (
  input  wire logic               ref_clk_in,      // 200 MHz clock
  input  wire logic               rst_n_in,        // Async reset, low
  input  wire logic [7:0]         reg_addr_in,     // Register address
  input  wire logic               reg_wr_in,       // Write strobe
  input  wire logic [7:0]         reg_wdata_in,    // Write data
  input  wire logic               reg_rd_in,       // Read strobe
  output logic      [7:0]         reg_rdata_out,   // Read data, next cycle
  input  wire grf_pkg::grf_sample_t raw_sample_in, // Filtered readings
  input  wire logic               frame_sync_pin_in, // External frame sync
  output grf_pkg::grf_sample_t    sample_out,      // Output registers
  output logic                    sample_strobe_out, // Output update pulse
  output logic      [3:0]         filter_mode_out, // Chosen filter mode
  output logic      [7:0]         fifo_data_out,   // FIFO byte
  output logic                    fifo_valid_out,  // FIFO not empty
  input  wire logic               fifo_ready_in    // FIFO pop
);
  localparam int TW = grf_pkg::TICK_WIDTH;
  initial
  begin
    if (TICK_1K < 1 || TICK_8K < 1 || TICK_32K < 1 || TICK_1K >= (1 << TW))
      $error("grf_top tick counts out of range");
  end

  // Registers
  logic [15:0] y_axis_user_offset_reg, y_axis_user_offset_next;
  logic [15:0] z_axis_user_offset_reg, z_axis_user_offset_next;
  logic [7:0]  rate_divider_value_reg, rate_divider_value_next;
  logic [7:0]  cfg_reg, cfg_next;        // Filter/sync/fifo configuration
  logic [7:0]  gyro_cfg_reg, gyro_cfg_next; // Gyro configuration
  logic [7:0]  fifo_en_reg, fifo_en_next; // FIFO source enables
  logic [7:0]  rdata_next;

  // Register writes and reads
  always_comb
  begin
    y_axis_user_offset_next = y_axis_user_offset_reg;
    z_axis_user_offset_next = z_axis_user_offset_reg;
    rate_divider_value_next = rate_divider_value_reg;
    cfg_next                = cfg_reg;
    gyro_cfg_next           = gyro_cfg_reg;
    fifo_en_next            = fifo_en_reg;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        grf_pkg::Y_AXIS_OFFSET_HIGH_ADDR: y_axis_user_offset_next[15:8] = reg_wdata_in;
        grf_pkg::Y_AXIS_OFFSET_LOW_ADDR:  y_axis_user_offset_next[7:0]  = reg_wdata_in;
        grf_pkg::Z_AXIS_OFFSET_HIGH_ADDR: z_axis_user_offset_next[15:8] = reg_wdata_in;
        grf_pkg::Z_AXIS_OFFSET_LOW_ADDR:  z_axis_user_offset_next[7:0]  = reg_wdata_in;
        grf_pkg::RATE_DIVIDER_ADDR:       rate_divider_value_next = reg_wdata_in;
        // Top bit must stay zero
        grf_pkg::FILTER_SYNC_FIFO_ADDR:   cfg_next = {1'b0, reg_wdata_in[6:0]};
        // Only the bypass bits live here
        grf_pkg::GYRO_CONFIG_ADDR:        gyro_cfg_next = {6'h00, reg_wdata_in[1:0]};
        grf_pkg::FIFO_ENABLE_ADDR:        fifo_en_next = {1'b0, reg_wdata_in[6:4], 4'h0};
        default: ; // Unmapped writes are ignored
      endcase
    end
    rdata_next = reg_rdata_out;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        grf_pkg::Y_AXIS_OFFSET_HIGH_ADDR: rdata_next = y_axis_user_offset_reg[15:8];
        grf_pkg::Y_AXIS_OFFSET_LOW_ADDR:  rdata_next = y_axis_user_offset_reg[7:0];
        grf_pkg::Z_AXIS_OFFSET_HIGH_ADDR: rdata_next = z_axis_user_offset_reg[15:8];
        grf_pkg::Z_AXIS_OFFSET_LOW_ADDR:  rdata_next = z_axis_user_offset_reg[7:0];
        grf_pkg::RATE_DIVIDER_ADDR:       rdata_next = rate_divider_value_reg;
        grf_pkg::FILTER_SYNC_FIFO_ADDR:   rdata_next = cfg_reg;
        grf_pkg::GYRO_CONFIG_ADDR:        rdata_next = gyro_cfg_reg;
        grf_pkg::FIFO_ENABLE_ADDR:        rdata_next = fifo_en_reg;
        default:                          rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      y_axis_user_offset_reg <= {grf_pkg::REG_RESET, grf_pkg::REG_RESET};
      z_axis_user_offset_reg <= {grf_pkg::REG_RESET, grf_pkg::REG_RESET};
      rate_divider_value_reg <= grf_pkg::REG_RESET;
      cfg_reg                <= grf_pkg::REG_RESET;
      gyro_cfg_reg           <= grf_pkg::REG_RESET;
      fifo_en_reg            <= grf_pkg::REG_RESET;
      reg_rdata_out          <= grf_pkg::REG_RESET;
    end
    else
    begin
      y_axis_user_offset_reg <= y_axis_user_offset_next;
      z_axis_user_offset_reg <= z_axis_user_offset_next;
      rate_divider_value_reg <= rate_divider_value_next;
      cfg_reg                <= cfg_next;
      gyro_cfg_reg           <= gyro_cfg_next;
      fifo_en_reg            <= fifo_en_next;
      reg_rdata_out          <= rdata_next;
    end
  end

  // Field views
  logic [1:0] filter_bypass_bits;
  logic [2:0] filter_setting;
  logic [2:0] sync_bit_select;
  logic       full_policy;
  assign filter_bypass_bits = gyro_cfg_reg[grf_pkg::BYPASS_LSB +: 2];
  assign filter_setting     = cfg_reg[grf_pkg::FILTER_SET_LSB +: 3];
  assign sync_bit_select    = cfg_reg[grf_pkg::SYNC_SEL_LSB +: 3];
  assign full_policy        = cfg_reg[grf_pkg::FULL_POLICY_BIT];

  // Rate and filter mode selection, internal tick and divided strobe
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next, tick_period;
  logic [7:0]    div_cnt_reg, div_cnt_next;
  logic [3:0]    mode_next;
  logic          tick, div_active, strobe_next;
  always_comb
  begin
    if (filter_bypass_bits[0])
    begin
      mode_next   = grf_pkg::MODE_WIDE_8173;
      tick_period = TW'(TICK_32K);
    end
    else if (filter_bypass_bits[1])
    begin
      mode_next   = grf_pkg::MODE_WIDE_3281;
      tick_period = TW'(TICK_32K);
    end
    else
    begin
      mode_next = {1'b0, filter_setting};
      if (filter_setting == grf_pkg::SET_LOWEST || filter_setting == grf_pkg::SET_HIGHEST)
        tick_period = TW'(TICK_8K);
      else
        tick_period = TW'(TICK_1K);
    end
    // Divider only with bypass 00 and setting strictly inside 0..7
    div_active = (filter_bypass_bits == 2'b00) && (filter_setting != grf_pkg::SET_LOWEST)
                 && (filter_setting != grf_pkg::SET_HIGHEST);
    tick          = (tick_cnt_reg >= tick_period - 1'b1);
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    div_cnt_next  = div_cnt_reg;
    strobe_next   = 1'b0;
    if (tick)
    begin
      if (!div_active)
        strobe_next = 1'b1;
      else if (div_cnt_reg == 8'h00)
      begin
        // Wrap: pulse and reload, giving rate/(1+divider)
        strobe_next  = 1'b1;
        div_cnt_next = rate_divider_value_reg;
      end
      else
        div_cnt_next = div_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_reg      <= '0;
      div_cnt_reg       <= 8'h00;
      filter_mode_out   <= 4'h0;
      sample_strobe_out <= 1'b0;
    end
    else
    begin
      tick_cnt_reg      <= tick_cnt_next;
      div_cnt_reg       <= div_cnt_next;
      filter_mode_out   <= mode_next;
      sample_strobe_out <= strobe_next;
    end
  end

  // Frame sync latch and output register update on the strobe
  logic                 sync_latch_reg, sync_latch_next;
  grf_pkg::grf_sample_t sample_next;
  always_comb
  begin
    // A strobe in the same cycle as a sync pulse keeps it for the next one
    if (strobe_next)
      sync_latch_next = frame_sync_pin_in;
    else
      sync_latch_next = sync_latch_reg | frame_sync_pin_in;
    sample_next = sample_out;
    if (strobe_next)
    begin
      sample_next.x    = raw_sample_in.x;
      sample_next.y    = raw_sample_in.y + y_axis_user_offset_reg;
      sample_next.z    = raw_sample_in.z + z_axis_user_offset_reg;
      sample_next.temp = raw_sample_in.temp;
      case (sync_bit_select)
        grf_pkg::SYNC_TEMP: sample_next.temp[0] = sync_latch_reg;
        grf_pkg::SYNC_X:    sample_next.x[0]    = sync_latch_reg;
        grf_pkg::SYNC_Y:    sample_next.y[0]    = sync_latch_reg;
        grf_pkg::SYNC_Z:    sample_next.z[0]    = sync_latch_reg;
        default: ; // Off or reserved: no capture
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync_latch_reg <= 1'b0;
      sample_out     <= '0;
    end
    else
    begin
      sync_latch_reg <= sync_latch_next;
      sample_out     <= sample_next;
    end
  end

  // Byte sequencer: on each strobe, queue the enabled axes of X, Y, Z, high then low bytes
  logic [5:0] pend_reg, pend_next;   // One bit per byte still to push
  logic [5:0] pick;                  // Pending bit of the byte on offer
  logic [7:0] push_byte;
  logic       push_valid, push_ready;
  always_comb
  begin
    pend_next  = pend_reg;
    push_valid = (pend_reg != 6'h00);
    push_byte  = 8'h00;
    if (pend_reg[5])      push_byte = sample_out.x[15:8];
    else if (pend_reg[4]) push_byte = sample_out.x[7:0];
    else if (pend_reg[3]) push_byte = sample_out.y[15:8];
    else if (pend_reg[2]) push_byte = sample_out.y[7:0];
    else if (pend_reg[1]) push_byte = sample_out.z[15:8];
    else if (pend_reg[0]) push_byte = sample_out.z[7:0];
    // Highest pending bit is the byte on offer; a later hit overrides
    pick = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (pend_reg[i])
        pick = 6'h01 << i;
    end
    // In drop policy a full FIFO refuses and the byte is discarded
    if (push_valid)
      pend_next = pend_reg & ~pick;
    // Outputs are fresh one cycle after the strobe
    if (sample_strobe_out)
      pend_next = {{2{fifo_en_reg[grf_pkg::X_FIFO_BIT]}},
                   {2{fifo_en_reg[grf_pkg::Y_FIFO_BIT]}},
                   {2{fifo_en_reg[grf_pkg::Z_FIFO_BIT]}}};
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pend_reg <= 6'h00;
    else
      pend_reg <= pend_next;
  end

  // Byte FIFO; overwrite when policy bit is zero drop when one
  grf_fifo #(
    .WIDTH (grf_pkg::FIFO_WIDTH),
    .DEPTH (grf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .overwrite_in  (!full_policy),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_byte),
    .out_valid_out (fifo_valid_out),
    .out_ready_in  (fifo_ready_in),
    .out_data_out  (fifo_data_out)
  );

  logic unused_ready;
  assign unused_ready = push_ready;
endmodule
